// ===== hw/universal_port_router.sv
// universal port router: apb registers and per-port peripheral signal routing
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
module universal_port_router #(
	parameter int LARGE_VARIANT = 1
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire port_router_pkg::peri_out_t    periOut,
	output port_router_pkg::peri_in_t          periIn,
	input  wire logic [31:0]                   gpioOut,
	input  wire logic [31:0]                   padIn,
	output logic      [31:0]                   padOut,
	output logic      [31:0]                   padOe
);

	if (LARGE_VARIANT != 0 && LARGE_VARIANT != 1) begin : g_bad_variant
		$error("LARGE_VARIANT must be 0 or 1");
	end

	logic [15:0] route   [port_router_pkg::ROUTE_REGS];
	logic [15:0] fncSel  [port_router_pkg::GROUPS];
	logic [7:0]  modeSel [port_router_pkg::GROUPS];
	logic [15:0] ioEn    [port_router_pkg::GROUPS];
	logic [15:0] next_route   [port_router_pkg::ROUTE_REGS];
	logic [15:0] next_fncSel  [port_router_pkg::GROUPS];
	logic [7:0]  next_modeSel [port_router_pkg::GROUPS];
	logic [15:0] next_ioEn    [port_router_pkg::GROUPS];
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic [31:0] padSync1;
	logic [31:0] padSync2;

	// pads come from outside the clock domain
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			padSync1 <= 32'h0;
			padSync2 <= 32'h0;
		end else begin
			padSync1 <= padIn;
			padSync2 <= padSync1;
		end
	end

	logic        access;
	logic [3:0]  word;
	logic [1:0]  grp;
	assign access = psel && penable && !pready;
	assign word   = paddr[5:2];
	assign grp    = paddr[3:2];

	// register writes and reads; answer one cycle into the access phase
	always_comb begin
		next_route   = route;
		next_fncSel  = fncSel;
		next_modeSel = modeSel;
		next_ioEn    = ioEn;
		next_prdata  = prdata;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		if (access) begin
			next_pready = 1'b1;
			next_prdata = 32'h0;
			if (paddr[1:0] != 2'h0 || paddr[11:7] != 5'h0) begin
				next_pslverr = 1'b1;
			end else if (paddr[6] == 1'b0) begin
				if (pwrite)
					next_route[word] = pwdata[15:0];
				next_prdata = {16'h0, route[word]};
			end else if (paddr[5:4] == 2'h0) begin
				if (pwrite)
					next_fncSel[grp] = pwdata[15:0];
				next_prdata = {16'h0, fncSel[grp]};
			end else if (paddr[5:4] == 2'h1) begin
				if (pwrite)
					next_modeSel[grp] = pwdata[7:0];
				next_prdata = {24'h0, modeSel[grp]};
			end else if (paddr[5:4] == 2'h2) begin
				if (pwrite)
					next_ioEn[grp] = pwdata[15:0];
				next_prdata = {16'h0, ioEn[grp]};
			end else begin
				next_prdata = {24'h0, padSync2[grp*8 +: 8]};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < port_router_pkg::ROUTE_REGS; i++)
				route[i] <= port_router_pkg::ROUTE_RESET;
			for (int g = 0; g < port_router_pkg::GROUPS; g++) begin
				fncSel[g]  <= port_router_pkg::FNCSEL_RESET;
				modeSel[g] <= port_router_pkg::MODSEL_RESET;
				ioEn[g]    <= port_router_pkg::IOEN_RESET;
			end
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			route   <= next_route;
			fncSel  <= next_fncSel;
			modeSel <= next_modeSel;
			ioEn    <= next_ioEn;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// per-port decode
	port_router_pkg::route_t portRoute [port_router_pkg::PORT_COUNT];
	logic [31:0] routed;
	logic [31:0] valid;
	logic [31:0] drv;
	logic [31:0] drvOe;
	logic [31:0] next_padOut;
	logic [31:0] next_padOe;
	port_router_pkg::peri_in_t next_periIn;

	function automatic logic chanOk(input logic [2:0] p, input logic [1:0] c);
		logic ok;
		ok = 1'b0;
		unique case (p)
			port_router_pkg::PERI_I2C:  ok = (c == 2'h0);
			port_router_pkg::PERI_SPI,
			port_router_pkg::PERI_UART: ok = (c <= 2'(LARGE_VARIANT));
			port_router_pkg::PERI_TMR:  ok = (c <= 2'(LARGE_VARIANT + 1));
			default:                    ok = 1'b0;
		endcase
		return ok;
	endfunction

	for (genvar k = 0; k < port_router_pkg::PORT_COUNT; k++) begin : g_port
		localparam int G = k / 8;
		localparam int B = k % 8;
		logic [2:0] pe;
		logic [1:0] ch;
		logic [2:0] fn;
		logic       fnOne;
		logic       modeOn;
		assign portRoute[k] = port_router_pkg::route_t'(
			route[k / 2][(k % 2) * port_router_pkg::ODD_LSB +: 8]);
		assign pe = portRoute[k].peri;
		assign ch = portRoute[k].ch;
		assign fn = portRoute[k].fn;
		// only function selector 0x1 connects the router
		assign fnOne  = fncSel[G][B*2 +: 2] == port_router_pkg::FUNCTION_ONE;
		// mode bit enables the peripheral path
		assign modeOn = modeSel[G][B];

		// any signal to any port; reserved codes invalid
		always_comb begin
			valid[k] = chanOk(pe, ch);
			drv[k]   = 1'b0;
			drvOe[k] = 1'b0;
			unique case (pe)
				port_router_pkg::PERI_I2C: begin
					valid[k] = valid[k] && (fn == 3'h1 || fn == 3'h2);
					drv[k]   = (fn == 3'h1) ? periOut.i2cSclOut : periOut.i2cSdaOut;
					drvOe[k] = (fn == 3'h1) ? periOut.i2cSclOe : periOut.i2cSdaOe;
				end
				port_router_pkg::PERI_SPI: begin
					valid[k] = valid[k] && fn >= 3'h1 && fn <= 3'h4;
					drv[k]   = (fn == 3'h2) ? periOut.spiDataOut[ch[0]]
					         : periOut.spiClkOut[ch[0]];
					drvOe[k] = (fn == 3'h2) || (fn == 3'h3 && periOut.spiClkOe[ch[0]]);
				end
				port_router_pkg::PERI_UART: begin
					valid[k] = valid[k] && (fn == 3'h1 || fn == 3'h2);
					drv[k]   = periOut.uartTxOut[ch[0]];
					drvOe[k] = (fn == 3'h2);
				end
				port_router_pkg::PERI_TMR: begin
					valid[k] = valid[k] && (fn == 3'h1 || fn == 3'h2) && ch != 2'h3;
					drv[k]   = (fn == 3'h1) ? periOut.tmrCc0Out[ch % 3]
					         : periOut.tmrCc1Out[ch % 3];
					drvOe[k] = (fn == 3'h1) ? periOut.tmrCc0Oe[ch % 3]
					         : periOut.tmrCc1Oe[ch % 3];
				end
				default: valid[k] = 1'b0;
			endcase
			routed[k] = fnOne && modeOn && valid[k];
		end

		// no assignment floats; shared output fans out identically
		always_comb begin
			if (!modeOn) begin
				next_padOut[k] = gpioOut[k];
				next_padOe[k]  = ioEn[G][B];
			end else begin
				next_padOut[k] = drv[k];
				next_padOe[k]  = routed[k] && drvOe[k];
			end
		end
	end

	// inputs: a peripheral input follows the port routed to it, else its idle level
	always_comb begin
		next_periIn = port_router_pkg::PERI_IN_IDLE;
		// relies on single routing per input; last port wins
		for (int k = 0; k < port_router_pkg::PORT_COUNT; k++) begin
			if (routed[k]) begin
				unique case (portRoute[k].peri)
					port_router_pkg::PERI_I2C:
						if (portRoute[k].fn == 3'h1) next_periIn.i2cSclIn = padSync2[k];
						else next_periIn.i2cSdaIn = padSync2[k];
					port_router_pkg::PERI_SPI:
						case (portRoute[k].fn)
							3'h1: next_periIn.spiDataIn[portRoute[k].ch[0]] = padSync2[k];
							3'h3: next_periIn.spiClkIn[portRoute[k].ch[0]] = padSync2[k];
							3'h4: next_periIn.spiSlaveSelect[portRoute[k].ch[0]] = padSync2[k];
							default: ;
						endcase
					port_router_pkg::PERI_UART:
						if (portRoute[k].fn == 3'h1)
							next_periIn.uartRxIn[portRoute[k].ch[0]] = padSync2[k];
					port_router_pkg::PERI_TMR:
						if (portRoute[k].fn == 3'h1)
							next_periIn.tmrCc0In[portRoute[k].ch % 3] = padSync2[k];
						else next_periIn.tmrCc1In[portRoute[k].ch % 3] = padSync2[k];
					default: ;
				endcase
			end
		end
	end

	// peripheral inputs are registered too, costing one cycle of input latency
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			padOut <= 32'h0;
			padOe  <= 32'h0;
			periIn <= port_router_pkg::PERI_IN_IDLE;
		end else begin
			padOut <= next_padOut;
			padOe  <= next_padOe;
			periIn <= next_periIn;
		end
	end

	// no drive from router unless function 1 selected
	property p_fn_gate;
		@(posedge ref_clk) disable iff (rst)
		(modeSel[0][0] && fncSel[0][1:0] != 2'h1) |=> !padOe[0];
	endproperty
	a_fn_gate: assert property (p_fn_gate) else $error("pad driven without function 1");

	// gpio mode follows the io enable
	property p_gpio;
		@(posedge ref_clk) disable iff (rst)
		!modeSel[0][3] |=> padOe[3] == $past(ioEn[0][3]);
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio enable not followed");

	property p_none;
		@(posedge ref_clk) disable iff (rst)
		(modeSel[0][0] && route[0][2:0] == 3'h0) |=> !padOe[0];
	endproperty
	a_none: assert property (p_none) else $error("unassigned port driven");

	property p_reserved;
		@(posedge ref_clk) disable iff (rst)
		(modeSel[0][1] && route[0][10:8] >= 3'h5) |=> !padOe[1];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code drove pad");

	// route write lands in register after the access
	property p_write;
		@(posedge ref_clk) disable iff (rst)
		(psel && penable && !pready && pwrite && paddr == 12'h000)
			|=> route[0] == $past(pwdata[15:0]);
	endproperty
	a_write: assert property (p_write) else $error("route write lost");

	// two ports routed to uart tx carry the same level
	property p_fanout;
		@(posedge ref_clk) disable iff (rst)
		(routed[0] && routed[1] && route[0] == 16'h4343) |=> padOut[0] == padOut[1];
	endproperty
	a_fanout: assert property (p_fanout) else $error("fan-out mismatch");

	// channel beyond the variant does not drive
	property p_chan;
		@(posedge ref_clk) disable iff (rst)
		(modeSel[0][0] && route[0][2:0] == 3'h1 && route[0][4:3] != 2'h0) |=> !padOe[0];
	endproperty
	a_chan: assert property (p_chan) else $error("bad channel drove pad");

	// uart tx on function 1 drives the pad
	property p_route;
		@(posedge ref_clk) disable iff (rst)
		(modeSel[0][0] && fncSel[0][1:0] == 2'h1 && route[0][7:0] == 8'h43) |=> padOe[0];
	endproperty
	a_route: assert property (p_route) else $error("routed output not driven");

endmodule

// ===== inc/port_router_pkg.sv
// shared constants and types of the universal port router
//
// Behaviour
// - any peripheral signal routable to any of 32 ports, eight in each of groups 0..3
// - routed signal reaches a port only while its function selector is 0x1
// - mode bit 0 gives general-purpose I/O, 1 enables the selected function
// - four 16-bit route registers per group, two ports each, fixed field layout
// - peripheral select 0 none, 1 I2C, 2 SPI, 3 UART, 4 timer, 5..7 reserved
// - channel field picks the instance; channel limits depend on the variant
// - function field picks the signal per peripheral type, 0 means none
// - no assignment with function 1 enabled leaves the pad high-impedance
// - one output routed to several ports drives the same waveform on each
package port_router_pkg;

	localparam int GROUPS     = 4;
	localparam int PORTS      = 8;
	localparam int PORT_COUNT = GROUPS * PORTS;
	localparam int ROUTE_REGS = PORT_COUNT / 2;

	// route registers at 0x000..0x03c, group g register n at (g*4+n)*4
	localparam logic [11:0] ROUTE_BASE   = 12'h000;
	// per group control words: function selectors, mode bits, io enables
	localparam logic [11:0] FNCSEL_BASE  = 12'h040;
	localparam logic [11:0] MODSEL_BASE  = 12'h050;
	localparam logic [11:0] IOEN_BASE    = 12'h060;
	localparam logic [11:0] PADIN_BASE   = 12'h070;

	localparam int PERI_LSB = 0;
	localparam int CH_LSB   = 3;
	localparam int FN_LSB   = 5;
	localparam int ODD_LSB  = 8;

	localparam logic [15:0] ROUTE_RESET  = 16'h0000;
	localparam logic [15:0] FNCSEL_RESET = 16'h0000;
	localparam logic [7:0]  MODSEL_RESET = 8'h00;
	localparam logic [15:0] IOEN_RESET   = 16'h0000;

	localparam logic [1:0] FUNCTION_ONE = 2'h1;

	typedef enum logic [2:0] {
		PERI_NONE = 3'h0,
		PERI_I2C  = 3'h1,
		PERI_SPI  = 3'h2,
		PERI_UART = 3'h3,
		PERI_TMR  = 3'h4
	} peri_t;

	typedef struct packed {
		logic [2:0] fn;
		logic [1:0] ch;
		logic [2:0] peri;
	} route_t;

	// peripheral signals facing the router, one bit per channel
	typedef struct packed {
		logic       i2cSclOut;
		logic       i2cSclOe;
		logic       i2cSdaOut;
		logic       i2cSdaOe;
		logic [1:0] spiDataOut;
		logic [1:0] spiClkOut;
		logic [1:0] spiClkOe;
		logic [1:0] uartTxOut;
		logic [2:0] tmrCc0Out;
		logic [2:0] tmrCc0Oe;
		logic [2:0] tmrCc1Out;
		logic [2:0] tmrCc1Oe;
	} peri_out_t;

	typedef struct packed {
		logic       i2cSclIn;
		logic       i2cSdaIn;
		logic [1:0] spiDataIn;
		logic [1:0] spiClkIn;
		logic [1:0] spiSlaveSelect;
		logic [1:0] uartRxIn;
		logic [2:0] tmrCc0In;
		logic [2:0] tmrCc1In;
	} peri_in_t;

	// idle levels seen by peripheral inputs that no port feeds
	localparam peri_in_t PERI_IN_IDLE = '{
		i2cSclIn: 1'b1, i2cSdaIn: 1'b1, spiDataIn: 2'h0, spiClkIn: 2'h0,
		spiSlaveSelect: 2'h3, uartRxIn: 2'h3, tmrCc0In: 3'h0, tmrCc1In: 3'h0
	};

endpackage

// ===== verification/peri_model.sv
// behavioural model of the peripherals that face the router
`timescale 1ns/10ps
module peri_model (
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	output port_router_pkg::peri_out_t      periOut
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;

	always_comb begin
		next_cnt = rst ? 8'h00 : cnt + 8'h01;
	end

	always_ff @(posedge ref_clk) begin
		cnt <= next_cnt;
	end

	// enables toggle too, so a pad that ignores them is caught
	always_comb begin
		periOut            = '0;
		periOut.i2cSclOe   = cnt[0];
		periOut.i2cSdaOe   = cnt[1];
		periOut.spiDataOut = cnt[2:1];
		periOut.spiClkOut  = cnt[1:0];
		periOut.spiClkOe   = cnt[4:3];
		periOut.uartTxOut  = cnt[3:2];
		periOut.tmrCc0Out  = cnt[2:0];
		periOut.tmrCc0Oe   = cnt[5:3];
		periOut.tmrCc1Out  = cnt[4:2];
		periOut.tmrCc1Oe   = ~cnt[6:4];
	end
endmodule

// ===== verification/universal_port_router_bench.sv
// self-checking bench of the universal port router
`timescale 1ns/10ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin failures++; \
	$display("mismatch at %0t got %h expected %h", $time, g, e); end end
module universal_port_router_bench;
	logic                        ref_clk = 1'b0;
	logic                        rst = 1'b1;
	logic                        psel = 1'b0;
	logic                        penable = 1'b0;
	logic                        pwrite = 1'b0;
	logic [11:0]                 paddr = 12'h000;
	logic [31:0]                 pwdata = 32'h00000000;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	port_router_pkg::peri_out_t  periOut;
	port_router_pkg::peri_out_t  prevOut;
	port_router_pkg::peri_in_t   periIn;
	logic [31:0]                 gpioOut = 32'h00000000;
	logic [31:0]                 padIn = 32'hffffffff;
	logic [31:0]                 padOut;
	logic [31:0]                 padOe;
	logic [31:0]                 rdata;
	logic                        rerr;
	int                          failures = 0;
	int                          nCompared = 0;
	logic [11:0] regA [4] = '{12'h03c, 12'h04c, 12'h05c, 12'h06c};
	logic [31:0] regM [4] = '{32'h0000ffff, 32'h0000ffff, 32'h000000ff, 32'h0000ffff};
	logic [7:0]  evenC [14] = '{8'h21, 8'h41, 8'h29, 8'h61, 8'h4a, 8'h6a, 8'ha2,
		8'h43, 8'h5b, 8'h34, 8'h54, 8'h3c, 8'h00, 8'h25};
	logic [7:0]  oddC [14] = '{8'h00, 8'h00, 8'h29, 8'h61, 8'h4a, 8'h00, 8'ha2,
		8'h43, 8'h5b, 8'h00, 8'h00, 8'h3c, 8'h00, 8'h25};

	always #10 ref_clk = ~ref_clk;

	always_ff @(posedge ref_clk) begin
		prevOut <= periOut;
	end

	universal_port_router #(.LARGE_VARIANT(1)) i_dut (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periOut(periOut), .periIn(periIn), .gpioOut(gpioOut),
		.padIn(padIn), .padOut(padOut), .padOe(padOe)
	);

	peri_model i_peri (.ref_clk(ref_clk), .rst(rst), .periOut(periOut));

	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// the watchdog ends a wait that never sees pready
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h00000000);
		`CHK(rerr, 1'b0)
		`CHK(rdata, e)
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// expected {drive, level} of a pad from its route byte
	function automatic logic [1:0] expf(input logic [7:0] b, input port_router_pkg::peri_out_t o);
		logic [1:0] ch;
		logic [2:0] fn;
		ch = b[4:3];
		fn = b[7:5];
		expf = 2'b00;
		case (b[2:0])
			3'h1: if (ch == 2'h0) begin
				if (fn == 3'h1) expf = {o.i2cSclOe, o.i2cSclOut};
				if (fn == 3'h2) expf = {o.i2cSdaOe, o.i2cSdaOut};
			end
			3'h2: if (ch <= 2'h1) begin
				if (fn == 3'h2) expf = {1'b1, o.spiDataOut[ch[0]]};
				if (fn == 3'h3) expf = {o.spiClkOe[ch[0]], o.spiClkOut[ch[0]]};
			end
			3'h3: if (ch <= 2'h1 && fn == 3'h2) expf = {1'b1, o.uartTxOut[ch[0]]};
			3'h4: if (ch <= 2'h2) begin
				if (fn == 3'h1) expf = {o.tmrCc0Oe[ch], o.tmrCc0Out[ch]};
				if (fn == 3'h2) expf = {o.tmrCc1Oe[ch], o.tmrCc1Out[ch]};
			end
			default: ;
		endcase
	endfunction

	task automatic pchk(input int p, input logic [1:0] e);
		`CHK(padOe[p], e[1])
		if (e[1]) `CHK(padOut[p], e[0])
	endtask

	task automatic route(input int g, input logic [11:0] ra, input logic [15:0] w,
		input logic [15:0] f, input logic [7:0] m);
		wr(port_router_pkg::IOEN_BASE + 12'(4 * g), 32'h00000000);
		wr(port_router_pkg::MODSEL_BASE + 12'(4 * g), 32'h00000000);
		// fields, function one, then mode bit
		wr(ra, {16'h0000, w});
		wr(port_router_pkg::FNCSEL_BASE + 12'(4 * g), {16'h0000, f});
		wr(port_router_pkg::MODSEL_BASE + 12'(4 * g), {24'h000000, m});
	endtask

	task end_of_test;
		$display("compared %0d failures %0d", nCompared, failures);
		if (failures == 0 && nCompared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#400000;
		failures++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (regA[i]) rchk(regA[i], 32'h00000000);
		foreach (regA[i]) begin
			wr(regA[i], 32'hffffffff);
			rchk(regA[i], regM[i]);
		end
		xfer(12'h080, 1'b0, 32'h00000000);
		`CHK(rerr, 1'b1)
		`CHK(rdata, 32'h00000000)
		xfer(12'h002, 1'b1, 32'hffffffff);
		`CHK(rerr, 1'b1)
		rchk(12'h000, 32'h00000000);
		tick(2);
		pchk(31, 2'b00);
		wr(port_router_pkg::IOEN_BASE, 32'h000000ff);
		gpioOut <= 32'h000000a5;
		tick(2);
		`CHK(padOe[7:0], 8'hff)
		`CHK(padOut[7:0], 8'ha5)
		foreach (evenC[i]) begin
			route(0, 12'h000, {oddC[i], evenC[i]}, 16'h0005, 8'h03);
			tick(1);
			repeat (4) begin
				tick(1);
				pchk(0, expf(evenC[i], prevOut));
				pchk(1, expf(oddC[i], prevOut));
			end
			if (oddC[i] == evenC[i]) `CHK(padOut[1:0] & padOe[1:0], padOut[0] ? padOe[1:0] : 2'b00)
			wr(port_router_pkg::FNCSEL_BASE, 32'h00000006);
			tick(2);
			pchk(0, 2'b00);
			pchk(1, expf(oddC[i], prevOut));
		end
		route(2, 12'h024, 16'h002b, 16'h0010, 8'h04);
		for (int v = 0; v < 2; v++) begin
			@(posedge ref_clk);
			padIn[18] <= v[0];
			tick(3);
			`CHK(periIn.uartRxIn[1], v[0])
			`CHK(padOe[18], 1'b0)
		end
		end_of_test();
	end
endmodule
